// ===== hw/dzsu_link_decode.v
// Link pointer to zone-select block offset decoder
`timescale 1ns/10ps

module dzsu_link_decode (
  ptr,
  blk_off
);
`include "dzsu_map.vh"
  input wire [31:0] ptr;
  output wire [9:0] blk_off;

  // ==========================================================
  // Most significant programmed zero picks the block
  // ==========================================================
  function [9:0] link_offset;
    input [31:0] p;
    integer i;
    reg [9:0] off;
    begin
      off = `DZ_BLK_FIRST;
      for (i = 0; i < `DZ_PTR_BITS; i = i + 1) begin
        if (!p[i]) begin
          off = `DZ_BLK_FIRST + `DZ_BLK_STEP + `DZ_BLK_STEP * i[9:0];
        end
      end
      link_offset = off;
    end
  endfunction

  assign blk_off = link_offset(ptr);
endmodule // dzsu_link_decode

// ===== hw/dzsu_map.vh
// Address map, field codes and OTP layout of the dual zone security unit
`ifndef DZSU_MAP_VH
`define DZSU_MAP_VH

// APB register byte offsets
`define DZ_OFF_KEY1 12'h000
`define DZ_OFF_KEY2 12'h010
`define DZ_OFF_STATUS 12'h020
`define DZ_OFF_INT_STAT 12'h024
`define DZ_OFF_INT_MASK 12'h028

// Status register fields
`define DZ_ST_UNLK1 0
`define DZ_ST_UNLK2 1
`define DZ_ST_GOFF1 2
`define DZ_ST_GOFF2 3
`define DZ_ST_TRIP 4
`define DZ_ST_LOADED 5

// Interrupt status fields
`define DZ_IS_UNLK1 0
`define DZ_IS_UNLK2 1
`define DZ_IS_TRIP 2
`define DZ_IS_DENY 3
`define DZ_INT_RESET 4'h0
`define DZ_MASK_RESET 4'h0

// Access kinds and target regions
`define DZ_KIND_FETCH 2'h0
`define DZ_KIND_READ 2'h1
`define DZ_KIND_WRITE 2'h2
`define DZ_RG_SECT 3'h0
`define DZ_RG_RAM 3'h1
`define DZ_RG_ROM 3'h2
`define DZ_RG_CLA 3'h3
`define DZ_RG_OTP 3'h4
`define DZ_RG_PSWD 3'h5

// OTP layout: settings regions per zone, link pointer at offset 0
`define DZ_Z1_OTP_BASE 10'h000
`define DZ_Z2_OTP_BASE 10'h200
`define DZ_WSTEP 10'h002
`define DZ_BLK_FIRST 10'h010
`define DZ_BLK_STEP 10'h010
`define DZ_PTR_BITS 30

// Word order inside a zone-select block
`define DZ_W_EXO_RAM 3'h0
`define DZ_W_EXO_SECT 3'h1
`define DZ_W_GRAB_RAM 3'h2
`define DZ_W_GRAB_SECT 3'h3
`define DZ_W_PSWD0 3'h4
`define DZ_W_LAST 3'h7

`endif

// ===== hw/dzsu_top.v
// Dual zone security unit: OTP settings loader, access guard, key check, APB
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps

module dzsu_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  irq,
  otp_req,
  otp_addr,
  otp_ack,
  otp_rdata,
  acc_valid,
  acc_kind,
  acc_region,
  acc_index,
  acc_zone,
  acc_grant,
  acc_deny,
  exec_zone,
  cpu_halt,
  dbg_attached,
  jtag_off,
  reg_mask,
  zone_unlocked
);
`include "dzsu_map.vh"
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  output reg irq;
  output reg otp_req;
  output reg [9:0] otp_addr;
  input wire otp_ack;
  input wire [31:0] otp_rdata;
  input wire acc_valid;
  input wire [1:0] acc_kind;
  input wire [2:0] acc_region;
  input wire [4:0] acc_index;
  input wire [1:0] acc_zone;
  output reg acc_grant;
  output reg acc_deny;
  input wire [1:0] exec_zone;
  input wire cpu_halt;
  input wire dbg_attached;
  output reg jtag_off;
  output reg reg_mask;
  output reg [1:0] zone_unlocked;

  localparam [2:0] LD_PTR = 3'b001;
  localparam [2:0] LD_BLK = 3'b010;
  localparam [2:0] LD_DONE = 3'b100;

  // Bit of a per-zone pair for zone code 1 or 2; zone 0 is unsecured
  function zbit;
    input [1:0] v;
    input [1:0] z;
    begin
      zbit = (z == 2'd1) ? v[0] : ((z == 2'd2) ? v[1] : 1'b0);
    end
  endfunction

  // ==========================================================
  // Settings loader
  // ==========================================================
  reg [2:0] ld_state_q;
  reg ld_zone_q;
  reg [2:0] ld_word_q;
  reg [9:0] blk_off_q;
  reg [31:0] cfg_q [0:15];
  wire [9:0] link_off;
  wire [9:0] zone_base;
  integer k;

  dzsu_link_decode u_link (
    .ptr(otp_rdata),
    .blk_off(link_off)
  );

  assign zone_base = ld_zone_q ? `DZ_Z2_OTP_BASE : `DZ_Z1_OTP_BASE;

  // Ownership is latched once after reset; later OTP changes need a reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state_q <= LD_PTR;
      ld_zone_q <= 1'b0;
      ld_word_q <= 3'h0;
      blk_off_q <= 10'h000;
      otp_req <= 1'b0;
      otp_addr <= 10'h000;
      for (k = 0; k < 16; k = k + 1) begin
        cfg_q[k] <= 32'hFFFFFFFF;
      end
    end else begin
      case (ld_state_q)
        LD_PTR: begin
          otp_req <= 1'b1;
          otp_addr <= zone_base;
          if (otp_req && otp_ack) begin
            blk_off_q <= link_off;
            otp_addr <= zone_base + link_off;
            ld_word_q <= 3'h0;
            ld_state_q <= LD_BLK;
          end
        end
        LD_BLK: begin
          if (otp_ack) begin
            cfg_q[{ld_zone_q, ld_word_q}] <= otp_rdata;
            otp_addr <= zone_base + blk_off_q + `DZ_WSTEP * {7'h00, ld_word_q + 3'h1};
            ld_word_q <= ld_word_q + 3'h1;
            if (ld_word_q == `DZ_W_LAST) begin
              otp_req <= 1'b0;
              ld_zone_q <= 1'b1;
              ld_state_q <= ld_zone_q ? LD_DONE : LD_PTR;
            end
          end
        end
        LD_DONE: begin
          otp_req <= 1'b0;
        end
        default: begin
          ld_state_q <= LD_PTR;
        end
      endcase
    end
  end

  wire loaded = (ld_state_q == LD_DONE);

  // ==========================================================
  // Debug probe presence, from another clock domain
  // ==========================================================
  reg dbg_meta_q;
  reg dbg_sync_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_meta_q <= 1'b0;
      dbg_sync_q <= 1'b0;
    end else begin
      dbg_meta_q <= dbg_attached;
      dbg_sync_q <= dbg_meta_q;
    end
  end

  // ==========================================================
  // Key registers, dummy-read tracking and unlock evaluation
  // ==========================================================
  reg [31:0] key_q [0:7];
  reg [7:0] pswd_rd_q;
  reg [1:0] unlk_q;
  reg [1:0] goff_q;
  reg trip_q;
  reg [1:0] full_ok;
  reg [1:0] low_ok;
  reg [127:0] pw;
  reg [127:0] ky;
  integer z;

  always @* begin
    full_ok = 2'b00;
    low_ok = 2'b00;
    pw = 128'h0;
    ky = 128'h0;
    for (z = 0; z < 2; z = z + 1) begin
      pw = {cfg_q[z*8+7], cfg_q[z*8+6], cfg_q[z*8+5], cfg_q[z*8+4]};
      ky = {key_q[z*4+3], key_q[z*4+2], key_q[z*4+1], key_q[z*4]};
      if (&pswd_rd_q[z*4 +: 4]) begin
        // All-zero password never unlocks, so such a zone stays locked
        full_ok[z] = (pw == {128{1'b1}}) || ((pw == ky) && (pw != 128'h0));
        low_ok[z] = (pw[63:0] == ky[63:0]) || (pw[63:0] == 64'h0);
      end
    end
  end

  // ==========================================================
  // Access guard
  // ==========================================================
  reg [1:0] own;
  reg exo;
  reg deny;

  always @* begin
    own = 2'd0;
    exo = 1'b0;
    case (acc_region)
      `DZ_RG_SECT: begin
        if (!cfg_q[3][acc_index]) begin
          own = 2'd1;
        end else if (!cfg_q[11][acc_index]) begin
          own = 2'd2;
        end
        exo = (own == 2'd1) ? !cfg_q[1][acc_index] : ((own == 2'd2) && !cfg_q[9][acc_index]);
      end
      `DZ_RG_RAM: begin
        if (!cfg_q[2][acc_index]) begin
          own = 2'd1;
        end else if (!cfg_q[10][acc_index]) begin
          own = 2'd2;
        end
        exo = (own == 2'd1) ? !cfg_q[0][acc_index] : ((own == 2'd2) && !cfg_q[8][acc_index]);
      end
      `DZ_RG_ROM, `DZ_RG_CLA: begin
        own = 2'd1;
      end
      default: begin
        own = 2'd0;
      end
    endcase
    deny = !loaded;
    if ((own != 2'd0) && !zbit(unlk_q, own) && (acc_zone != own)) begin
      deny = 1'b1;
    end
    if (exo && (acc_kind != `DZ_KIND_FETCH)) begin
      deny = 1'b1;
    end
    if (((acc_region == `DZ_RG_OTP) || (acc_region == `DZ_RG_PSWD)) &&
        (acc_kind == `DZ_KIND_FETCH)) begin
      deny = 1'b1;
    end
  end

  wire prot_hit = acc_valid && (own != 2'd0) && !zbit(unlk_q, own) && !zbit(goff_q, own);
  wire halt_hit = cpu_halt && (exec_zone != 2'd0) && !zbit(goff_q, exec_zone);
  wire pswd_read = acc_valid && loaded && (acc_region == `DZ_RG_PSWD) &&
                   (acc_kind == `DZ_KIND_READ);

  // ==========================================================
  // APB slave, one wait state, registered answer
  // ==========================================================
  reg [3:0] ist_q;
  reg [3:0] imask_q;
  wire apb_acc = psel && penable;
  wire apb_done = apb_acc && pready;
  wire key_hit = (paddr[11:5] == 7'h00);
  wire ist_rd = (paddr == `DZ_OFF_INT_STAT);
  wire [3:0] ev;
  wire [3:0] ist_d;
  reg [31:0] rd_val;
  reg rd_err;

  assign ev = {acc_valid && deny, !trip_q && (halt_hit || (dbg_sync_q && prot_hit)),
               full_ok & ~unlk_q};
  // Clear only the bits the read returned, so an event after the capture survives
  assign ist_d = (ist_q & ~((apb_done && !pwrite && ist_rd) ? prdata[3:0] : 4'h0)) | ev;

  always @* begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    if (key_hit) begin
      rd_val = 32'h00000000;
    end else if (paddr == `DZ_OFF_STATUS) begin
      rd_val[`DZ_ST_UNLK1] = unlk_q[0];
      rd_val[`DZ_ST_UNLK2] = unlk_q[1];
      rd_val[`DZ_ST_GOFF1] = goff_q[0];
      rd_val[`DZ_ST_GOFF2] = goff_q[1];
      rd_val[`DZ_ST_TRIP] = trip_q;
      rd_val[`DZ_ST_LOADED] = loaded;
    end else if (ist_rd) begin
      rd_val = {28'h0000000, ist_q};
    end else if (paddr == `DZ_OFF_INT_MASK) begin
      rd_val = {28'h0000000, imask_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  integer j;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      imask_q <= `DZ_MASK_RESET;
      ist_q <= `DZ_INT_RESET;
      irq <= 1'b0;
      for (j = 0; j < 8; j = j + 1) begin
        key_q[j] <= 32'h00000000;
      end
    end else begin
      pready <= apb_acc && !pready;
      if (apb_acc && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
        pslverr <= rd_err;
      end else begin
        pslverr <= 1'b0;
      end
      if (apb_done && pwrite) begin
        if (key_hit) begin
          key_q[paddr[4:2]] <= pwdata;
        end
        if (paddr == `DZ_OFF_INT_MASK) begin
          imask_q <= pwdata[3:0];
        end
      end
      ist_q <= ist_d;
      irq <= |(ist_d & imask_q);
    end
  end

  // ==========================================================
  // Zone state, guard trip and register masking
  // ==========================================================
  // No hold-in-reset for a debugger exists; attach via software wait loop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pswd_rd_q <= 8'h00;
      unlk_q <= 2'b00;
      goff_q <= 2'b00;
      trip_q <= 1'b0;
      acc_grant <= 1'b0;
      acc_deny <= 1'b0;
      jtag_off <= 1'b0;
      reg_mask <= 1'b0;
      zone_unlocked <= 2'b00;
    end else begin
      if (pswd_read) begin
        pswd_rd_q[acc_index[2:0]] <= 1'b1;
      end
      // Re-evaluated every cycle: a wrong key relocks the zone
      unlk_q <= full_ok;
      goff_q <= low_ok;
      if (halt_hit) begin
        trip_q <= 1'b1;
      end
      if (dbg_sync_q && prot_hit) begin
        trip_q <= 1'b1;
      end
      jtag_off <= trip_q;
      acc_grant <= acc_valid && !deny;
      acc_deny <= acc_valid && deny;
      reg_mask <= (exec_zone != 2'd0) && !zbit(unlk_q, exec_zone);
      // Tracks the internal state in the same cycle, never a cycle behind it
      zone_unlocked <= full_ok;
    end
  end
endmodule // dzsu_top

// ===== test/dzsu_otp_model.sv
// Settings store model answering the unit's loader port
`timescale 1ns/10ps
module dzsu_otp_model (
  input wire pclk,
  input wire presetn,
  input wire otp_req,
  input wire [9:0] otp_addr,
  output reg otp_ack,
  output reg [31:0] otp_rdata
);
  reg [31:0] mem [0:1023];
  reg [1:0] wait_q;
  integer i;
  // ==========================================
  // Contents
  initial begin
    for (i = 0; i < 1024; i = i + 1)
      mem[i] = 32'hFFFFFFFF;
    mem[10'h200] = 32'hFFFFFFFE;
    mem[10'h012] = 32'hFFFFFFF7;
    mem[10'h014] = 32'hFFFFFFFE;
    mem[10'h016] = 32'hFFFFFFF5;
    mem[10'h226] = 32'hFFFFFFFB;
    mem[10'h018] = 32'h13579BDF;
    mem[10'h01A] = 32'h2468ACE0;
    mem[10'h01C] = 32'h0F1E2D3C;
    mem[10'h01E] = 32'h4B5A6978;
  end
  // ==========================================
  // Answer
  // Delay varies with the address so that prompt and slow answers both occur
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_ack <= 1'b0;
      wait_q <= 2'h0;
      otp_rdata <= 32'h0;
    end else if (otp_req && !otp_ack && wait_q == 2'h0) begin
      otp_ack <= 1'b1;
      otp_rdata <= mem[otp_addr];
      wait_q <= otp_addr[2:1];
    end else begin
      otp_ack <= 1'b0;
      otp_rdata <= ~otp_rdata;
      if (wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
    end
  end
endmodule // dzsu_otp_model

// ===== test/dzsu_top_asserts.sv
// Port checks of the dual zone security unit
`timescale 1ns/10ps
`include "dzsu_map.vh"
module dzsu_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire otp_req,
  input wire [9:0] otp_addr,
  input wire otp_ack,
  input wire acc_valid,
  input wire [1:0] acc_kind,
  input wire [2:0] acc_region,
  input wire [1:0] acc_zone,
  input wire acc_grant,
  input wire acc_deny,
  input wire [1:0] exec_zone,
  input wire jtag_off,
  input wire reg_mask,
  input wire [1:0] zone_unlocked
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_answer_once: assert property (acc_valid |=> acc_grant ^ acc_deny)
    else $error("access not answered once");
  a_no_stray: assert property (!acc_valid |=> !(acc_grant || acc_deny))
    else $error("answer without request");
  a_otp_no_exec: assert property (acc_valid && acc_kind == `DZ_KIND_FETCH &&
    acc_region == `DZ_RG_OTP |=> acc_deny) else $error("fetch from settings granted");
  a_rom_first_zone: assert property (acc_valid && acc_region == `DZ_RG_ROM &&
    acc_zone == 2'h2 && !zone_unlocked[0] |=> acc_deny) else $error("rom not first zone");
  a_guard_sticky: assert property (jtag_off |=> jtag_off)
    else $error("guard trip released");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slverr without ready");
  a_mask_locked: assert property ((exec_zone == 2'h1 && !zone_unlocked[0])[*2] |-> reg_mask)
    else $error("registers not masked");
  a_mask_free: assert property ((exec_zone == 2'h0)[*2] |-> !reg_mask)
    else $error("registers masked outside secure code");
  a_otp_hold: assert property (otp_req && !otp_ack |=> otp_req && $stable(otp_addr))
    else $error("settings request dropped");
  a_reset_locked: assert property ($rose(presetn) |-> zone_unlocked == 2'h0)
    else $error("zone open after reset");
  cover property (acc_valid ##1 acc_grant);
  cover property ($rose(jtag_off));
  cover property ($rose(zone_unlocked[0]));
endmodule // dzsu_chk
bind dzsu_top dzsu_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .otp_req, .otp_addr, .otp_ack, .acc_valid, .acc_kind, .acc_region, .acc_zone,
  .acc_grant, .acc_deny, .exec_zone, .jtag_off, .reg_mask, .zone_unlocked);

// ===== test/test_dual_zone_code_security.sv
// Self-checking bench of the dual zone security unit
`timescale 1ns/10ps
`include "dzsu_map.vh"
module test_dual_zone_code_security;
  reg pclk, presetn, psel, penable, pwrite, acc_valid, cpu_halt, dbg_attached, err_q;
  reg [11:0] paddr, w;
  reg [31:0] pwdata, rd_q, xs_q;
  reg [1:0] acc_kind, acc_zone, exec_zone, unl;
  reg [2:0] acc_region;
  reg [4:0] acc_index;
  wire [31:0] prdata, otp_rdata;
  wire [9:0] otp_addr;
  wire [1:0] zone_unlocked;
  wire pready, pslverr, irq, otp_req, otp_ack, acc_grant, acc_deny, jtag_off, reg_mask;
  integer failures, num_checks;
  dzsu_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .otp_req, .otp_addr, .otp_ack, .otp_rdata, .acc_valid,
    .acc_kind, .acc_region, .acc_index, .acc_zone, .acc_grant, .acc_deny, .exec_zone,
    .cpu_halt, .dbg_attached, .jtag_off, .reg_mask, .zone_unlocked);
  dzsu_otp_model i_otp (.pclk, .presetn, .otp_req, .otp_addr, .otp_ack, .otp_rdata);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ==========================================
  // Helpers
  task chk(input [31:0] e, input [31:0] g, input [79:0] what);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [31:0] pw(input [1:0] n);
    pw = i_otp.mem[10'h018 + {7'h0, n, 1'b0}];
  endfunction
  // Owner map follows the claims held in the settings model
  function exp_g(input [1:0] k, input [2:0] r, input [4:0] x, input [1:0] z);
    reg [1:0] o;
    begin
      if (r >= 3'h2 || (r == 3'h0 && (x == 5'h1 || x == 5'h3)) || (r == 3'h1 && x == 5'h0))
        o = 2'h1;
      else if (r == 3'h0 && x == 5'h2)
        o = 2'h2;
      else
        o = 2'h0;
      exp_g = !((r == 3'h0 && x == 5'h3 && k != `DZ_KIND_FETCH) ||
        (o != 2'h0 && !unl[o - 2'h1] && z != o));
    end
  endfunction
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task acc(input [1:0] k, input [2:0] r, input [4:0] x, input [1:0] z, input g);
    begin
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_kind <= k;
      acc_region <= r;
      acc_index <= x;
      acc_zone <= z;
      @(posedge pclk);
      acc_valid <= 1'b0;
      @(negedge pclk);
      chk({30'h0, g, !g}, {30'h0, acc_grant, acc_deny}, "access");
    end
  endtask
  task rnd(input integer cnt);
    integer c;
    reg [1:0] k, z;
    reg [2:0] r;
    reg [4:0] x;
    begin
      for (c = 0; c < cnt; c = c + 1) begin
        xs_q = xs(xs_q);
        k = xs_q[1:0] % 2'h3;
        r = {1'b0, xs_q[3:2]};
        x = {2'h0, xs_q[6:4] % 3'h5};
        z = xs_q[9:8] % 2'h3;
        acc(k, r, x, z, exp_g(k, r, x, z));
      end
    end
  endtask
  task wait_loaded;
    begin
      rd_q = 32'h0;
      while (rd_q[`DZ_ST_LOADED] !== 1'b1)
        apb(1'b0, `DZ_OFF_STATUS, 32'h0);
    end
  endtask
  // ==========================================
  // Sequence
  initial begin
    {psel, penable, pwrite, acc_valid, cpu_halt, dbg_attached, presetn} = 7'h0;
    {paddr, pwdata, acc_kind, acc_zone, exec_zone, acc_region, acc_index} = 58'h0;
    unl = 2'h0;
    xs_q = 32'h28;
    failures = 0;
    num_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    acc(`DZ_KIND_READ, `DZ_RG_ROM, 5'h0, 2'h1, 1'b0);
    wait_loaded;
    chk(32'h20, rd_q, "status");
    apb(1'b0, `DZ_OFF_INT_MASK, 32'h0);
    chk(32'h0, rd_q, "mask");
    apb(1'b0, 12'h030, 32'h0);
    chk(32'h1, {31'h0, err_q}, "slverr");
    apb(1'b1, `DZ_OFF_INT_MASK, 32'hF);
    rnd(60);
    acc(`DZ_KIND_FETCH, `DZ_RG_OTP, 5'h0, 2'h1, 1'b0);
    for (w = 12'h0; w < 12'h4; w = w + 12'h1)
      acc(`DZ_KIND_READ, `DZ_RG_PSWD, 5'h4 + w[4:0], 2'h0, 1'b1);
    apb(1'b0, `DZ_OFF_STATUS, 32'h0);
    chk(32'h22, rd_q, "z2 unlock");
    unl = 2'b10;
    chk(32'h1, {31'h0, irq}, "irq");
    apb(1'b0, `DZ_OFF_INT_STAT, 32'h0);
    chk(32'h2, rd_q & 32'h7, "int stat");
    apb(1'b0, `DZ_OFF_INT_STAT, 32'h0);
    chk(32'h0, rd_q, "int clear");
    repeat (2) @(posedge pclk);
    chk(32'h0, {31'h0, irq}, "irq low");
    exec_zone <= 2'h1;
    // Upper half wrong: only the debug guard may open
    for (w = 12'h0; w < 12'h4; w = w + 12'h1)
      apb(1'b1, `DZ_OFF_KEY1 + 12'h4 * w, w < 12'h2 ? pw(w[1:0]) : ~pw(w[1:0]));
    for (w = 12'h0; w < 12'h4; w = w + 12'h1)
      acc(`DZ_KIND_READ, `DZ_RG_PSWD, w[4:0], 2'h0, 1'b1);
    apb(1'b0, `DZ_OFF_KEY1, 32'h0);
    chk(32'h0, rd_q, "key read");
    apb(1'b0, `DZ_OFF_STATUS, 32'h0);
    chk(32'h26, rd_q, "guard off");
    chk(32'h1, {31'h0, reg_mask}, "reg mask");
    cpu_halt <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'h0, {31'h0, jtag_off}, "no trip");
    cpu_halt <= 1'b0;
    for (w = 12'h2; w < 12'h4; w = w + 12'h1)
      apb(1'b1, `DZ_OFF_KEY1 + 12'h4 * w, pw(w[1:0]));
    apb(1'b0, `DZ_OFF_STATUS, 32'h0);
    chk(32'h27, rd_q, "unlock");
    unl = 2'b11;
    chk(32'h0, {31'h0, reg_mask}, "unmask");
    rnd(20);
    apb(1'b1, `DZ_OFF_KEY1, ~pw(2'h0));
    apb(1'b0, `DZ_OFF_STATUS, 32'h0);
    chk(32'h22, rd_q, "relock");
    unl = 2'b10;
    cpu_halt <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'h1, {31'h0, jtag_off}, "trip");
    cpu_halt <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'h0, {29'h0, jtag_off, zone_unlocked}, "reset");
    unl = 2'b00;
    exec_zone <= 2'h0;
    dbg_attached <= 1'b1;
    wait_loaded;
    acc(`DZ_KIND_READ, `DZ_RG_CLA, 5'h0, 2'h0, 1'b0);
    repeat (4) @(posedge pclk);
    chk(32'h1, {31'h0, jtag_off}, "probe trip");
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    failures = failures + 1;
    wrap_up;
  end
endmodule // test_dual_zone_code_security
